/* verilog/cpu_status_operand_regs.sv */
`timescale 1ns/10ps
`include "cpu_status_regs.svh"
module cpu_status_operand_regs
	import cpu_status_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        ctl_rd,
	input  wire logic        ctl_wr,
	input  wire logic [11:0] ctl_code,
	input  wire logic        psw_rd,
	input  wire logic        psw_wr,
	input  wire logic        flags_rd,
	input  wire logic        flags_wr,
	input  wire logic [31:0] ctl_wdata,
	output logic      [31:0] ctl_rdata,
	output logic             priv_viol,
	output logic             super_mode,
	input  wire logic        exc_ret,
	input  wire logic [15:0] exc_ret_psw,
	input  wire logic        int_take,
	input  wire logic        instr_done,
	output logic             trace_req,
	input  wire logic [2:0]  irq_level,
	input  wire logic        irq_l7_edge,
	output logic             irq_pending,
	input  wire logic [9:0]  vec_disp,
	output logic      [31:0] vec_addr,
	input  wire logic        acc_fetch,
	input  wire logic        acc_slot,
	output logic      [31:0] acc_attr,
	output logic      [31:0] cache_config,
	output logic      [31:0] onchip_ram_base_a,
	output logic      [31:0] onchip_ram_base_b,
	output logic      [31:0] peripheral_space_base,
	input  wire logic        op_wr,
	input  op_size_t         op_size,
	input  wire logic        op_dst_addr,
	input  wire logic [2:0]  op_dst_num,
	input  wire logic [31:0] op_data,
	input  wire logic [3:0]  op_rd_idx,
	output logic      [31:0] op_rd_data,
	input  wire logic [2:0]  ea_mode,
	input  wire logic [2:0]  ea_reg,
	output ea_kind_t         ea_kind,
	output logic             ea_bad,
	input  wire logic [1:0]  mem_addr,
	input  op_size_t         mem_size,
	input  wire logic [31:0] mem_data,
	output logic      [3:0]  mem_lanes,
	output logic      [31:0] mem_bus
);
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [3:0] size_lanes(input op_size_t sz);
		return (sz == SZ_BYTE) ? `LANES_BYTE :
		       (sz == SZ_WORD) ? `LANES_WORD : `LANES_LONG;
	endfunction : size_lanes

	// Lane 3 carries the byte at the lowest address.
	function automatic logic [3:0] be_lanes(input op_size_t sz,
	                                        input logic [1:0] a);
		logic [3:0] base;
		base = size_lanes(sz);
		unique case (sz)
			SZ_BYTE: return base << (2'h3 - a);
			SZ_WORD: return base << {~a[1], 1'b0};
			default: return base;
		endcase
	endfunction : be_lanes

	function automatic logic [31:0] be_place(input op_size_t sz,
	                                         input logic [31:0] d);
		unique case (sz)
			SZ_BYTE: return {4{d[7:0]}};
			SZ_WORD: return {2{d[15:0]}};
			default: return d;
		endcase
	endfunction : be_place

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [15:0]          psw_ff;
	logic [31:`ETB_LSB]   etb_ff;
	logic [31:0]          cache_cfg_ff;
	logic [31:0]          attr_ff [4];
	logic [31:0]          ram_a_ff;
	logic [31:0]          ram_b_ff;
	logic [31:0]          periph_ff;
	logic [31:0]          rdata_ff;
	logic                 viol_ff;
	logic                 trace_ff;
	logic                 irq_ff;
	logic [31:0]          vec_ff;
	logic [31:0]          attr_out_ff;
	ea_kind_t             ea_kind_ff;
	logic [3:0]           mem_lanes_ff;
	logic [31:0]          mem_bus_ff;

	// ------------------------------------------------------------
	// Privilege and decode
	// ------------------------------------------------------------
	logic        sup;
	logic [2:0]  imask;
	logic        any_priv;
	logic        allowed;
	logic        hit_cache;
	logic        hit_attr;
	logic        hit_etb;
	logic        hit_ram_a;
	logic        hit_ram_b;
	logic        hit_periph;
	logic        movec_wr;
	logic [31:0] ctl_mux;
	logic [31:0] nxt_rdata;

	assign sup      = psw_ff[`PSW_S_BIT];
	assign imask    = psw_ff[`PSW_MSK_HI:`PSW_MSK_LO];
	assign any_priv = ctl_rd | ctl_wr | psw_rd | psw_wr;
	assign allowed  = sup | ~any_priv;
	assign movec_wr = ctl_wr & sup;

	assign hit_cache  = ctl_code == `RC_CACHE_CFG;
	assign hit_attr   = ctl_code[11:2] == `RC_ATTR_GRP;
	assign hit_etb    = ctl_code == `RC_ETB;
	assign hit_ram_a  = ctl_code == `RC_RAM_A;
	assign hit_ram_b  = ctl_code == `RC_RAM_B;
	assign hit_periph = ctl_code == `RC_PERIPH;

	// Unmapped codes read as zero and ignore writes.
	assign ctl_mux = hit_cache  ? cache_cfg_ff :
	                 hit_attr   ? attr_ff[ctl_code[1:0]] :
	                 hit_etb    ? {etb_ff, `ETB_ZEROS} :
	                 hit_ram_a  ? ram_a_ff :
	                 hit_ram_b  ? ram_b_ff :
	                 hit_periph ? periph_ff : 32'h0;

	assign nxt_rdata = !allowed ? 32'h0 :
	                   psw_rd   ? {16'h0, psw_ff} :
	                   flags_rd ? {24'h0, psw_ff[7:0]} :
	                   ctl_rd   ? ctl_mux : rdata_ff;

	// ------------------------------------------------------------
	// Status word update
	// ------------------------------------------------------------
	logic [15:0] psw_wr_val;
	logic [15:0] psw_ret_val;
	logic [15:0] nxt_psw;

	// Flags writes keep the upper byte whatever the mode.
	assign psw_wr_val =
		(psw_wr & sup) ? (ctl_wdata[15:0] & `PSW_IMPL) :
		flags_wr ? {psw_ff[15:8], ctl_wdata[7:0] & `FLAGS_IMPL} :
		psw_ff;
	assign psw_ret_val = exc_ret ? (exc_ret_psw & `PSW_IMPL) : psw_wr_val;
	// Interrupt entry wins over a same-cycle write of bit 12.
	assign nxt_psw = int_take ? (psw_ret_val & ~`PSW_M_MASK)
	                          : psw_ret_val;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			psw_ff <= `PSW_RESET;
		end else begin
			psw_ff <= nxt_psw;
		end
	end

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			etb_ff       <= '0;
			cache_cfg_ff <= 32'h0;
			ram_a_ff     <= 32'h0;
			ram_b_ff     <= 32'h0;
			periph_ff    <= 32'h0;
			for (int i = 0; i < 4; i++) begin
				attr_ff[i] <= 32'h0;
			end
		end else if (movec_wr) begin
			if (hit_etb) begin
				etb_ff <= ctl_wdata[31:`ETB_LSB];
			end
			if (hit_cache) begin
				cache_cfg_ff <= ctl_wdata;
			end
			if (hit_attr) begin
				attr_ff[ctl_code[1:0]] <= ctl_wdata;
			end
			if (hit_ram_a) begin
				ram_a_ff <= ctl_wdata;
			end
			if (hit_ram_b) begin
				ram_b_ff <= ctl_wdata;
			end
			if (hit_periph) begin
				periph_ff <= ctl_wdata;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			rdata_ff <= 32'h0;
			viol_ff  <= 1'b0;
		end else begin
			rdata_ff <= nxt_rdata;
			viol_ff  <= ~allowed;
		end
	end

	// ------------------------------------------------------------
	// Trace, interrupt gating, vector and attribute lookup
	// ------------------------------------------------------------
	logic        nxt_irq;
	logic [31:0] nxt_vec;

	assign nxt_irq = irq_l7_edge | (irq_level > imask);
	assign nxt_vec = {etb_ff, `ETB_ZEROS} + {22'h0, vec_disp};

	always_ff @(posedge clk) begin
		if (!nrst) begin
			trace_ff    <= 1'b0;
			irq_ff      <= 1'b0;
			vec_ff      <= 32'h0;
			attr_out_ff <= 32'h0;
		end else begin
			trace_ff    <= instr_done & psw_ff[`PSW_T_BIT];
			irq_ff      <= nxt_irq;
			vec_ff      <= nxt_vec;
			attr_out_ff <= attr_ff[{acc_fetch, acc_slot}];
		end
	end

	// ------------------------------------------------------------
	// Operand writes into the register file
	// ------------------------------------------------------------
	logic [31:0] gpr_wdata;
	logic [3:0]  gpr_lanes;

	// Address destinations take all four lanes and, below long size, a sign-extended word.
	assign gpr_wdata = (op_dst_addr && op_size != SZ_LONG)
	                 ? {{16{op_data[15]}}, op_data[15:0]}
	                 : op_data;
	assign gpr_lanes = op_dst_addr ? `LANES_LONG
	                 : size_lanes(op_size);

	gpr_file u_gpr (
		.clk      (clk),
		.nrst     (nrst),
		.wr_en    (op_wr),
		.wr_idx   ({op_dst_addr, op_dst_num}),
		.wr_lanes (gpr_lanes),
		.wr_data  (gpr_wdata),
		.rd_idx   (op_rd_idx),
		.rd_data  (op_rd_data)
	);

	// ------------------------------------------------------------
	// Addressing mode decode and big-endian memory lanes
	// ------------------------------------------------------------
	ea_kind_t ea_kind_w;

	ea_decoder u_ea (
		.mode (ea_mode),
		.regf (ea_reg),
		.kind (ea_kind_w)
	);

	always_ff @(posedge clk) begin
		if (!nrst) begin
			ea_kind_ff   <= EA_BAD;
			mem_lanes_ff <= `LANES_NONE;
			mem_bus_ff   <= 32'h0;
		end else begin
			ea_kind_ff   <= ea_kind_w;
			mem_lanes_ff <= be_lanes(mem_size, mem_addr);
			mem_bus_ff   <= be_place(mem_size, mem_data);
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign ctl_rdata             = rdata_ff;
	assign priv_viol             = viol_ff;
	assign super_mode            = sup;
	assign trace_req             = trace_ff;
	assign irq_pending           = irq_ff;
	assign vec_addr              = vec_ff;
	assign acc_attr              = attr_out_ff;
	assign cache_config          = cache_cfg_ff;
	assign onchip_ram_base_a     = ram_a_ff;
	assign onchip_ram_base_b     = ram_b_ff;
	assign peripheral_space_base = periph_ff;
	assign ea_kind               = ea_kind_ff;
	assign ea_bad                = ea_kind_ff == EA_BAD;
	assign mem_lanes             = mem_lanes_ff;
	assign mem_bus               = mem_bus_ff;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_user_psw_kept;
		@(posedge clk) disable iff (!nrst)
		psw_wr && !sup && !flags_wr && !exc_ret && !int_take
		|=> psw_ff == $past(psw_ff) && priv_viol;
	endproperty
	a_user_psw_kept: assert property (p_user_psw_kept)
		else $error("user write changed the status word");

	property p_reset_psw;
		@(posedge clk) disable iff (!nrst)
		$rose(nrst) |-> psw_ff[15:8] == `PSW_RESET >> 8;
	endproperty
	a_reset_psw: assert property (p_reset_psw)
		else $error("status upper byte wrong after reset");

	property p_trace;
		@(posedge clk) disable iff (!nrst)
		instr_done |=> trace_req == $past(psw_ff[`PSW_T_BIT]);
	endproperty
	a_trace: assert property (p_trace)
		else $error("trace request does not follow trace bit");

	property p_m_clear;
		@(posedge clk) disable iff (!nrst)
		int_take |=> (psw_ff & `PSW_M_MASK) == 16'h0;
	endproperty
	a_m_clear: assert property (p_m_clear)
		else $error("interrupt entry left bit 12 set");

	property p_irq_mask;
		@(posedge clk) disable iff (!nrst)
		!irq_l7_edge ##0 (irq_level <= imask) |=> !irq_pending;
	endproperty
	a_irq_mask: assert property (p_irq_mask)
		else $error("masked interrupt level passed");

	property p_vec;
		@(posedge clk) disable iff (!nrst)
		1'b1 |=> vec_addr[31:20] == $past(etb_ff) &&
		         vec_addr[19:0] == {10'h000, $past(vec_disp)};
	endproperty
	a_vec: assert property (p_vec)
		else $error("vector address wrong");

	property p_attr_split;
		@(posedge clk) disable iff (!nrst)
		!acc_fetch |=> acc_attr == $past(attr_ff[{1'b0, acc_slot}]);
	endproperty
	a_attr_split: assert property (p_attr_split)
		else $error("data access used a fetch attribute");

	property p_rsvd_zero;
		@(posedge clk) disable iff (!nrst)
		(psw_ff & ~`PSW_IMPL) == 16'h0;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero)
		else $error("reserved status bit set");

	property p_flags_rd;
		@(posedge clk) disable iff (!nrst)
		flags_rd && !psw_rd |=> ctl_rdata[31:8] == 24'h0 &&
		                        ctl_rdata[7:0] == $past(psw_ff[7:0]);
	endproperty
	a_flags_rd: assert property (p_flags_rd)
		else $error("flags read returned upper bits");

	property p_addr_sext;
		@(posedge clk) disable iff (!nrst)
		op_wr && op_dst_addr && op_size == SZ_WORD
		|-> gpr_lanes == `LANES_LONG &&
		    gpr_wdata[31:16] == {16{op_data[15]}};
	endproperty
	a_addr_sext: assert property (p_addr_sext)
		else $error("address destination not sign-extended");

	property p_be_word;
		@(posedge clk) disable iff (!nrst)
		mem_size == SZ_WORD && !mem_addr[1]
		|=> mem_lanes == 4'hc && mem_bus[31:24] == $past(mem_data[15:8]);
	endproperty
	a_be_word: assert property (p_be_word)
		else $error("word high byte not at lower address");
endmodule : cpu_status_operand_regs

/* verilog/cpu_status_regs.svh */
`ifndef CPU_STATUS_REGS_SVH
`define CPU_STATUS_REGS_SVH
// ----------------------------------------------------------------
// Processor status word layout
// ----------------------------------------------------------------
`define PSW_T_BIT    15
`define PSW_S_BIT    13
`define PSW_M_MASK   16'h1000
`define PSW_MSK_HI   10
`define PSW_MSK_LO   8
`define PSW_RESET    16'h2700
`define PSW_IMPL     16'hb71f
`define FLAGS_IMPL   8'h1f
`define PSW_ZERO_HI  8'h00
// ----------------------------------------------------------------
// Exception table base
// ----------------------------------------------------------------
`define ETB_LSB      20
`define ETB_ZEROS    20'h00000
// ----------------------------------------------------------------
// Control register move codes
// ----------------------------------------------------------------
`define RC_CACHE_CFG 12'h002
`define RC_ATTR_GRP  10'h001
`define RC_ETB       12'h801
`define RC_RAM_A     12'hc04
`define RC_RAM_B     12'hc05
`define RC_PERIPH    12'hc0f
// ----------------------------------------------------------------
// Byte lane patterns
// ----------------------------------------------------------------
`define LANES_NONE   4'h0
`define LANES_BYTE   4'h1
`define LANES_WORD   4'h3
`define LANES_LONG   4'hf
// ----------------------------------------------------------------
// Effective address mode and register field codes
// ----------------------------------------------------------------
`define EA_M_DREG    3'h0
`define EA_M_AREG    3'h1
`define EA_M_IND     3'h2
`define EA_M_POSTINC 3'h3
`define EA_M_PREDEC  3'h4
`define EA_M_DISP16  3'h5
`define EA_M_INDEX8  3'h6
`define EA_M_EXT     3'h7
`define EA_X_ABS_W   3'h0
`define EA_X_ABS_L   3'h1
`define EA_X_PC_DISP 3'h2
`define EA_X_PC_IDX  3'h3
`define EA_X_IMM     3'h4
`endif

/* verilog/cpu_status_pkg.sv */
package cpu_status_pkg;
	typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} op_size_t;
	typedef enum logic [3:0] {
		EA_DREG, EA_AREG, EA_IND, EA_POSTINC, EA_PREDEC, EA_DISP16,
		EA_INDEX8, EA_PC_DISP, EA_PC_INDEX, EA_ABS_W, EA_ABS_L,
		EA_IMM, EA_BAD
	} ea_kind_t;
endpackage : cpu_status_pkg

/* verilog/gpr_file.sv */
`timescale 1ns/10ps
module gpr_file (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        wr_en,
	input  wire logic [3:0]  wr_idx,
	input  wire logic [3:0]  wr_lanes,
	input  wire logic [31:0] wr_data,
	input  wire logic [3:0]  rd_idx,
	output logic      [31:0] rd_data
);
	logic [31:0] mem [16];
	logic [31:0] rd_data_ff;

	// Only the enabled byte lanes change; the rest keep their value.
	always_ff @(posedge clk) begin
		for (int i = 0; i < 4; i++) begin
			if (wr_en && wr_lanes[i]) begin
				mem[wr_idx][i*8 +: 8] <= wr_data[i*8 +: 8];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			rd_data_ff <= 32'h0;
		end else begin
			rd_data_ff <= mem[rd_idx];
		end
	end

	assign rd_data = rd_data_ff;
endmodule : gpr_file

/* verilog/ea_decoder.sv */
`timescale 1ns/10ps
`include "cpu_status_regs.svh"
module ea_decoder
	import cpu_status_pkg::*;
(
	input  wire logic [2:0] mode,
	input  wire logic [2:0] regf,
	output ea_kind_t        kind
);
	always_comb begin
		unique case (mode)
			`EA_M_DREG:    kind = EA_DREG;
			`EA_M_AREG:    kind = EA_AREG;
			`EA_M_IND:     kind = EA_IND;
			`EA_M_POSTINC: kind = EA_POSTINC;
			`EA_M_PREDEC:  kind = EA_PREDEC;
			`EA_M_DISP16:  kind = EA_DISP16;
			`EA_M_INDEX8:  kind = EA_INDEX8;
			`EA_M_EXT: begin
				unique case (regf)
					`EA_X_PC_DISP: kind = EA_PC_DISP;
					`EA_X_PC_IDX:  kind = EA_PC_INDEX;
					`EA_X_ABS_W:   kind = EA_ABS_W;
					`EA_X_ABS_L:   kind = EA_ABS_L;
					`EA_X_IMM:     kind = EA_IMM;
					default:       kind = EA_BAD;
				endcase
			end
		endcase
	end
endmodule : ea_decoder

/* verif/tb_cpu_status_operand_regs.sv */
`timescale 1ns/10ps
module tb_cpu_status_operand_regs
	import cpu_status_pkg::*;
;
// ----------------------------------------------------------------
// Stimulus, model state and instance
// ----------------------------------------------------------------
logic clk = 1'b0, nrst = 1'b0, ctl_rd = 1'b0, ctl_wr = 1'b0;
logic psw_rd = 1'b0, psw_wr = 1'b0, flags_rd = 1'b0, flags_wr = 1'b0;
logic exc_ret = 1'b0, int_take = 1'b0, instr_done = 1'b0;
logic irq_l7_edge = 1'b0, acc_fetch = 1'b0, acc_slot = 1'b0;
logic op_wr = 1'b0, op_dst_addr = 1'b0;
logic [11:0] ctl_code = 12'h000;
logic [31:0] ctl_wdata = 32'h0, op_data = 32'h0, mem_data = 32'h0;
logic [15:0] exc_ret_psw = 16'h0;
logic [2:0]  irq_level = 3'h0, op_dst_num = 3'h0;
logic [2:0]  ea_mode = 3'h0, ea_reg = 3'h0;
logic [9:0]  vec_disp = 10'h0;
logic [3:0]  op_rd_idx = 4'h0;
logic [1:0]  mem_addr = 2'h0;
op_size_t    op_size = SZ_BYTE, mem_size = SZ_BYTE;
logic [31:0] ctl_rdata, vec_addr, acc_attr, cache_config, op_rd_data;
logic [31:0] onchip_ram_base_a, onchip_ram_base_b, peripheral_space_base;
logic [31:0] mem_bus, rs = 32'hd586, base, e, m32;
logic [31:0] gpr [16];
logic [31:0] av [4];
logic [3:0]  mem_lanes, l4;
logic        priv_viol, super_mode, trace_req, irq_pending, ea_bad;
ea_kind_t    ea_kind, ek;
int          error_cnt = 0, num_checks = 0, cyc = 0;

cpu_status_operand_regs i_cpu_status_operand_regs (.clk, .nrst, .ctl_rd,
	.ctl_wr, .ctl_code, .psw_rd, .psw_wr, .flags_rd, .flags_wr, .ctl_wdata,
	.ctl_rdata, .priv_viol, .super_mode, .exc_ret, .exc_ret_psw, .int_take,
	.instr_done, .trace_req, .irq_level, .irq_l7_edge, .irq_pending,
	.vec_disp, .vec_addr, .acc_fetch, .acc_slot, .acc_attr, .cache_config,
	.onchip_ram_base_a, .onchip_ram_base_b, .peripheral_space_base, .op_wr,
	.op_size, .op_dst_addr, .op_dst_num, .op_data, .op_rd_idx, .op_rd_data,
	.ea_mode, .ea_reg, .ea_kind, .ea_bad, .mem_addr, .mem_size, .mem_data,
	.mem_lanes, .mem_bus);

always #50 clk = ~clk;
always @(posedge clk) begin
	cyc <= cyc + 1;
	if (cyc == 6000) begin
		error_cnt++;
		test_done();
	end
end
// ----------------------------------------------------------------
// Shared tasks
// ----------------------------------------------------------------
function automatic logic [31:0] nx(input logic [31:0] s);
	return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
endfunction : nx
task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
	num_checks++;
	if (s !== x) begin
		error_cnt++;
		$display("Error %s expected %h seen %h", nm, x, s);
	end
endtask : chk
task automatic test_done;
	$display("checks %0d mismatches %0d", num_checks, error_cnt);
	if (error_cnt == 0 && num_checks > 0)
		$display("SIMULATION PASSED");
	else
		$display("SIMULATION FAILED");
	$finish;
endtask : test_done
localparam logic [10:0] do_crd = 11'h400, do_cwr = 11'h200, do_prd = 11'h100,
	do_pwr = 11'h080, do_frd = 11'h040, do_fwr = 11'h020, do_ret = 11'h010,
	do_int = 11'h008, do_ins = 11'h004, do_nmi = 11'h002, do_opw = 11'h001;
// All strobes are written once per cycle, so each request drops the strobes of the one before.
task automatic go(input logic [10:0] s);
	{ctl_rd, ctl_wr, psw_rd, psw_wr, flags_rd, flags_wr, exc_ret, int_take,
		instr_done, irq_l7_edge, op_wr} = s;
	@(posedge clk);
	#1;
endtask : go
task automatic step;
	go(11'h000);
endtask : step
task automatic cw(input logic [11:0] c, input logic [31:0] d);
	ctl_code = c;
	ctl_wdata = d;
	go(do_cwr);
endtask : cw
task automatic cr(input logic [11:0] c, input logic [31:0] x);
	ctl_code = c;
	go(do_crd);
	chk("ctl_rdata", ctl_rdata, x);
endtask : cr
task automatic pw(input logic [15:0] d);
	ctl_wdata = {16'h0, d};
	go(do_pwr);
endtask : pw
task automatic pr(input logic [15:0] x);
	go(do_prd);
	chk("status", ctl_rdata, {16'h0, x});
endtask : pr
task automatic gw(input int sz, input logic a, input logic [2:0] n);
	rs = nx(rs);
	op_size = op_size_t'(sz);
	op_dst_addr = a;
	op_dst_num = n;
	op_data = rs;
	if (a)
		gpr[{a, n}] = (sz == 2) ? rs : {{16{rs[15]}}, rs[15:0]};
	else if (sz == 0)
		gpr[{a, n}][7:0] = rs[7:0];
	else if (sz == 1)
		gpr[{a, n}][15:0] = rs[15:0];
	else
		gpr[{a, n}] = rs;
	go(do_opw);
	op_rd_idx = {a, n};
	step();
	chk("gpr", op_rd_data, gpr[{a, n}]);
endtask : gw
// ----------------------------------------------------------------
// Main sequence
// ----------------------------------------------------------------
initial begin
	repeat (10) @(posedge clk);
	#1 nrst = 1'b1;
	chk("super_mode", super_mode, 1);
	chk("ea_bad", ea_bad, 1);
	go(do_prd);
	chk("status_hi", ctl_rdata[31:8], 24'h27);
	cr(12'h002, 0);
	$display("test reset done");
	pw(16'hffff);
	pr(16'hb71f);
	chk("priv_viol", priv_viol, 0);
	pw(16'h2015);
	pr(16'h2015);
	ctl_wdata = 32'hffff_ffff;
	go(do_fwr);
	go(do_frd);
	chk("flags", ctl_rdata, 32'h1f);
	pr(16'h201f);
	$display("test status done");
	pw(16'ha700);
	go(do_ins);
	chk("trace_req", trace_req, 1);
	step();
	chk("trace_req", trace_req, 0);
	pw(16'h2700);
	go(do_ins);
	chk("trace_req", trace_req, 0);
	pw(16'h3700);
	pr(16'h3700);
	go(do_int);
	pr(16'h2700);
	exc_ret_psw = 16'h3000;
	go(do_ret);
	pr(16'h3000);
	$display("test trace and master done");
	for (int m = 0; m < 8; m++) begin
		pw(16'h2000 | 16'(m << 8));
		for (int l = 0; l < 8; l++) begin
			irq_level = l[2:0];
			step();
			chk("irq_pending", irq_pending, l > m);
		end
	end
	irq_level = 3'h0;
	go(do_nmi);
	chk("irq_pending", irq_pending, 1);
	$display("test interrupt mask done");
	for (int i = 0; i < 8; i++) begin
		rs = nx(rs);
		base = {rs[31:20], 20'h0};
		cw(12'h801, rs);
		cr(12'h801, base);
		rs = nx(rs);
		vec_disp = rs[9:0];
		step();
		chk("vec_addr", vec_addr, base + rs[9:0]);
	end
	rs = nx(rs);
	cw(12'h002, rs);
	chk("cache_config", cache_config, rs);
	cw(12'hc04, rs & 32'hffff_f800);
	chk("ram_a", onchip_ram_base_a, rs & 32'hffff_f800);
	cw(12'hc05, rs & 32'h0fff_f800);
	chk("ram_b", onchip_ram_base_b, rs & 32'h0fff_f800);
	cw(12'hc0f, ~rs);
	chk("periph", peripheral_space_base, ~rs);
	cw(12'h123, rs);
	cr(12'h123, 0);
	for (int k = 0; k < 4; k++) begin
		rs = nx(rs);
		av[k] = rs;
		cw(12'(4 + k), rs);
	end
	for (int k = 0; k < 4; k++) begin
		{acc_fetch, acc_slot} = k[1:0];
		step();
		chk("acc_attr", acc_attr, av[k]);
	end
	$display("test control registers done");
	exc_ret_psw = 16'h0000;
	go(do_ret);
	chk("super_mode", super_mode, 0);
	pw(16'h2700);
	chk("priv_viol", priv_viol, 1);
	chk("super_mode", super_mode, 0);
	cw(12'h801, 32'h0);
	chk("priv_viol", priv_viol, 1);
	go(do_prd);
	chk("priv_viol", priv_viol, 1);
	chk("ctl_rdata", ctl_rdata, 0);
	ctl_wdata = 32'h0000_ff0a;
	go(do_fwr);
	go(do_frd);
	chk("flags", ctl_rdata, 32'h0a);
	chk("super_mode", super_mode, 0);
	exc_ret_psw = 16'h2700;
	go(do_ret);
	cr(12'h801, base);
	$display("test user mode done");
	for (int i = 0; i < 16; i++)
		gw(2, i[3], i[2:0]);
	for (int i = 0; i < 48; i++) begin
		rs = nx(rs);
		gw(rs % 3, rs[4], rs[7:5]);
	end
	$display("test register file done");
	for (int m = 0; m < 8; m++) begin
		for (int r = 0; r < 8; r++) begin
			{ea_mode, ea_reg} = {m[2:0], r[2:0]};
			step();
			ek = (m < 7) ? ea_kind_t'(m) : (r == 0) ? EA_ABS_W :
				(r == 1) ? EA_ABS_L : (r == 2) ? EA_PC_DISP :
				(r == 3) ? EA_PC_INDEX : (r == 4) ? EA_IMM : EA_BAD;
			chk("ea_kind", 32'(ea_kind), 32'(ek));
			chk("ea_bad", ea_bad, ek == EA_BAD);
		end
	end
	$display("test address modes done");
	for (int c = 0; c < 7; c++) begin
		rs = nx(rs);
		mem_data = rs;
		mem_size = op_size_t'((c < 4) ? 0 : (c < 6) ? 1 : 2);
		mem_addr = (c < 4) ? c[1:0] : (c == 5) ? 2'h2 : 2'h0;
		e = (c < 4) ? {24'h0, rs[7:0]} << (8 * (3 - c)) :
			(c == 4) ? {rs[15:0], 16'h0} : (c == 5) ? {16'h0, rs[15:0]} : rs;
		m32 = (c < 4) ? 32'hff << (8 * (3 - c)) : (c == 4) ? 32'hffff_0000 :
			(c == 5) ? 32'h0000_ffff : 32'hffff_ffff;
		l4 = {m32[24], m32[16], m32[8], m32[0]};
		step();
		chk("mem_lanes", mem_lanes, l4);
		chk("mem_bus", mem_bus & m32, e);
	end
	$display("test memory order done");
	{ea_mode, ea_reg} = 6'h00;
	cw(12'h002, 32'h1);
	pw(16'h0715);
	nrst = 1'b0;
	step();
	step();
	nrst = 1'b1;
	chk("ea_bad", ea_bad, 1);
	chk("mem_lanes", mem_lanes, 0);
	chk("cache_config", cache_config, 0);
	chk("super_mode", super_mode, 1);
	go(do_prd);
	chk("status_hi", ctl_rdata[31:8], 24'h27);
	$display("test second reset done");
	test_done();
end
endmodule : tb_cpu_status_operand_regs
